// file: rtl/snr_pkg.sv
// Constants and types shared by the sensor host register block
// Overview of operation
// - An 8-bit mailbox register hands parameter values from the parameter store to the host.
// - Status bit 2 shows the device awake and bit 1 shows it suspended waiting on a measurement.
// - Status bit 0 shows the lowest power state, bits 7 to 3 read zero and the register resets to zero.
// - Parameters sit outside the register map and are reached only by fetch and store commands.
// - Parameter offsets 0x07, 0x08 and 0x09 hold the input selection for proximity channels one to three.
// - Parameter offset 0x05 holds alignment bits 6, 5, 4 for channels three, two, one; low bits are stored as written but unused.
// - The auxiliary word, shared with the UV level, sits in a low and a high byte that reset to zero.
// - A set alignment bit reports the low 16 bits of the 17-bit conversion, a clear one the upper 16.
package snr_pkg;
  localparam logic [6:0] DEV_ADDR        = 7'h5A;
  localparam logic [7:0] OFS_PROX3_HIGH  = 8'h2B;
  localparam logic [7:0] OFS_AUX_LOW     = 8'h2C;
  localparam logic [7:0] OFS_AUX_HIGH    = 8'h2D;
  localparam logic [7:0] OFS_READBACK    = 8'h2E;
  localparam logic [7:0] OFS_STATUS      = 8'h30;
  localparam logic [7:0] OFS_COMMAND     = 8'h31;
  localparam logic [7:0] OFS_PARAM_VALUE = 8'h32;
  localparam logic [7:0] OFS_KEY_FIRST   = 8'h3B;
  localparam logic [7:0] OFS_KEY_LAST    = 8'h3E;
  localparam logic [7:0] RST_BYTE        = 8'h00;
  localparam int         STAT_AWAKE_BIT  = 2;
  localparam int         STAT_SUSP_BIT   = 1;
  localparam int         STAT_SLEEP_BIT  = 0;
  localparam logic [4:0] PARAM_CHANNEL_ENABLE_LIST    = 5'h01;
  localparam logic [4:0] PARAM_ALIGN     = 5'h05;
  localparam logic [4:0] PARAM_PROX1_SEL = 5'h07;
  localparam int         ALIGN_PROX1_BIT = 4;
  localparam int         PARAM_DEPTH     = 32;
  localparam int         PROX_CHANNELS   = 3;
  localparam logic [2:0] CMD_FETCH       = 3'h4;
  localparam logic [2:0] CMD_STORE       = 3'h5;
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;

  typedef enum logic [6:0] {
    ST_IDLE      = 7'h01,
    ST_ADDR      = 7'h02,
    ST_ACK_ADDR  = 7'h04,
    ST_WRITE     = 7'h08,
    ST_ACK_WRITE = 7'h10,
    ST_READ      = 7'h20,
    ST_ACK_READ  = 7'h40
  } snr_link_state_t;
endpackage

// file: rtl/snr_param_ram.sv
// Parameter store reached only through fetch and store commands
`timescale 1ns/1ps
`default_nettype none
module snr_param_ram
  import snr_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       req_in,
  input  wire logic       we_in,
  input  wire logic [4:0] addr_in,
  input  wire logic [7:0] wdata_in,
  output logic      [7:0] rdata_out,
  output logic            ack_out
);
  logic [7:0] mem_q [PARAM_DEPTH];
  logic [7:0] mem_d [PARAM_DEPTH];
  logic [7:0] rdata_d;

  // Store echoes the written value so the mailbox follows it
  always_comb begin
    mem_d   = mem_q;
    rdata_d = rdata_out;
    if (req_in) begin
      if (we_in) begin
        mem_d[addr_in] = wdata_in;
        rdata_d        = wdata_in;
      end else begin
        rdata_d = mem_q[addr_in];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < PARAM_DEPTH; i++) begin
        mem_q[i] <= RST_BYTE;
      end
      rdata_out <= RST_BYTE;
      ack_out   <= 1'b0;
    end else begin
      mem_q     <= mem_d;
      rdata_out <= rdata_d;
      ack_out   <= req_in;
    end
  end
endmodule
`default_nettype wire

// file: rtl/snr_regs.sv
// Sensor host register block with two-wire serial slave and parameter commands
`timescale 1ns/1ps
`default_nettype none
module snr_regs
  import snr_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oen_out,
  input  wire logic        awake_in,
  input  wire logic        suspend_in,
  input  wire logic        sleep_in,
  input  wire logic        conv_valid_in,
  input  wire logic [1:0]  conv_chan_in,
  input  wire logic [16:0] conv_data_in,
  input  wire logic        aux_valid_in,
  input  wire logic [15:0] aux_data_in,
  output logic      [15:0] prox_word_out,
  output logic      [1:0]  prox_word_chan_out,
  output logic             prox_word_valid_out,
  output logic      [23:0] prox_input_select_out,
  output logic      [7:0]  channel_enable_list_out
);
  logic [2:0]      scl_sync_q;
  logic [2:0]      sda_sync_q;
  logic            scl_q;
  logic            sda_q;
  logic            scl_new;
  logic            sda_new;
  logic            scl_rise;
  logic            scl_fall;
  logic            start_ev;
  logic            stop_ev;
  snr_link_state_t st_q;
  snr_link_state_t st_d;
  logic [3:0]      bit_q;
  logic [3:0]      bit_d;
  logic [7:0]      sh_q;
  logic [7:0]      sh_d;
  logic [7:0]      ptr_q;
  logic [7:0]      ptr_d;
  logic            rw_q;
  logic            rw_d;
  logic            first_q;
  logic            first_d;
  logic            oen_d;
  logic            reg_we;
  logic [7:0]      rd_byte;
  logic [7:0]      key_idx;
  logic [7:0]      prox3_high_q;
  logic [7:0]      prox3_high_d;
  logic [7:0]      aux_low_q;
  logic [7:0]      aux_low_d;
  logic [7:0]      aux_high_q;
  logic [7:0]      aux_high_d;
  logic [7:0]      readback_q;
  logic [7:0]      readback_d;
  logic [7:0]      status_q;
  logic [7:0]      status_d;
  logic [7:0]      param_value_q;
  logic [7:0]      param_value_d;
  logic            param_req_q;
  logic            param_req_d;
  logic            param_we_q;
  logic            param_we_d;
  logic [4:0]      param_addr_q;
  logic [4:0]      param_addr_d;
  logic [7:0]      param_rdata;
  logic            param_ack;
  logic [7:0]      channel_enable_list_d;
  logic [7:0]      align_q;
  logic [7:0]      align_d;
  logic [7:0]      key_q [4];
  logic [7:0]      key_d [4];
  logic [15:0]     aligned_word;
  logic [15:0]     prox_word_d;
  logic [1:0]      prox_chan_d;
  logic            store_hit;

  // Pin synchronisers; a level counts once stages two and three agree
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], scl_in};
      sda_sync_q <= {sda_sync_q[1:0], sda_in};
      scl_q      <= scl_new;
      sda_q      <= sda_new;
    end
  end

  always_comb begin
    scl_new  = (scl_sync_q[1] == scl_sync_q[2]) ? scl_sync_q[2] : scl_q;
    sda_new  = (sda_sync_q[1] == sda_sync_q[2]) ? sda_sync_q[2] : sda_q;
    scl_rise = scl_new & ~scl_q;
    scl_fall = ~scl_new & scl_q;
    start_ev = scl_q & scl_new & sda_q & ~sda_new;
    stop_ev  = scl_q & scl_new & ~sda_q & sda_new;
  end

  // Serial slave: address, pointer byte, then auto-incremented data bytes
  always_comb begin
    st_d    = st_q;
    bit_d   = bit_q;
    sh_d    = sh_q;
    ptr_d   = ptr_q;
    rw_d    = rw_q;
    first_d = first_q;
    oen_d   = sda_oen_out;
    reg_we  = 1'b0;
    if (stop_ev) begin
      st_d  = ST_IDLE;
      oen_d = 1'b1;
    end else if (start_ev) begin
      st_d  = ST_ADDR;
      bit_d = 4'h0;
      oen_d = 1'b1;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          st_d = ST_IDLE;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], sda_new};
            bit_d = bit_q + 4'h1;
          end else if (scl_fall && bit_q == BITS_PER_BYTE) begin
            if (sh_q[7:1] == DEV_ADDR) begin
              oen_d = 1'b0;
              rw_d  = sh_q[0];
              st_d  = ST_ACK_ADDR;
            end else begin
              st_d = ST_IDLE;
            end
          end
        end
        ST_ACK_ADDR: begin
          if (scl_fall) begin
            bit_d = 4'h0;
            if (rw_q) begin
              sh_d  = rd_byte;
              oen_d = rd_byte[7];
              st_d  = ST_READ;
            end else begin
              oen_d   = 1'b1;
              first_d = 1'b1;
              st_d    = ST_WRITE;
            end
          end
        end
        ST_WRITE: begin
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], sda_new};
            bit_d = bit_q + 4'h1;
          end else if (scl_fall && bit_q == BITS_PER_BYTE) begin
            oen_d = 1'b0;
            st_d  = ST_ACK_WRITE;
            if (first_q) begin
              ptr_d = sh_q;
            end else begin
              reg_we = 1'b1;
              ptr_d  = ptr_q + 8'h01;
            end
          end
        end
        ST_ACK_WRITE: begin
          if (scl_fall) begin
            oen_d   = 1'b1;
            bit_d   = 4'h0;
            first_d = 1'b0;
            st_d    = ST_WRITE;
          end
        end
        ST_READ: begin
          if (scl_rise) begin
            bit_d = bit_q + 4'h1;
          end else if (scl_fall) begin
            if (bit_q == BITS_PER_BYTE) begin
              oen_d = 1'b1;
              ptr_d = ptr_q + 8'h01;
              st_d  = ST_ACK_READ;
            end else begin
              sh_d  = {sh_q[6:0], 1'b0};
              oen_d = sh_q[6];
            end
          end
        end
        ST_ACK_READ: begin
          if (scl_rise && sda_new) begin
            st_d = ST_IDLE;
          end else if (scl_fall) begin
            sh_d  = rd_byte;
            oen_d = rd_byte[7];
            bit_d = 4'h0;
            st_d  = ST_READ;
          end
        end
        default: begin
          st_d = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q        <= ST_IDLE;
      bit_q       <= 4'h0;
      sh_q        <= RST_BYTE;
      ptr_q       <= RST_BYTE;
      rw_q        <= 1'b0;
      first_q     <= 1'b0;
      sda_oen_out <= 1'b1;
      sda_out     <= 1'b0;
    end else begin
      st_q        <= st_d;
      bit_q       <= bit_d;
      sh_q        <= sh_d;
      ptr_q       <= ptr_d;
      rw_q        <= rw_d;
      first_q     <= first_d;
      sda_oen_out <= oen_d;
      sda_out     <= 1'b0;
    end
  end

  // Read map; parameter offsets are not mapped and read zero
  always_comb begin
    key_idx = ptr_q - OFS_KEY_FIRST;
    rd_byte = RST_BYTE;
    if (ptr_q >= OFS_KEY_FIRST && ptr_q <= OFS_KEY_LAST) begin
      rd_byte = key_q[key_idx[1:0]];
    end else begin
      unique case (ptr_q)
        OFS_PROX3_HIGH:  rd_byte = prox3_high_q;
        OFS_AUX_LOW:     rd_byte = aux_low_q;
        OFS_AUX_HIGH:    rd_byte = aux_high_q;
        OFS_READBACK:    rd_byte = readback_q;
        OFS_STATUS:      rd_byte = status_q;
        OFS_PARAM_VALUE: rd_byte = param_value_q;
        default:         rd_byte = RST_BYTE;
      endcase
    end
  end

  // Register file; hardware updates win over a host write in the same cycle
  always_comb begin
    prox3_high_d  = prox3_high_q;
    aux_low_d     = aux_low_q;
    aux_high_d    = aux_high_q;
    readback_d    = readback_q;
    param_value_d = param_value_q;
    param_req_d   = 1'b0;
    param_we_d    = param_we_q;
    param_addr_d  = param_addr_q;
    key_d         = key_q;
    store_hit     = param_req_q & param_we_q;
    channel_enable_list_d      = (store_hit && param_addr_q == PARAM_CHANNEL_ENABLE_LIST) ? param_value_q : channel_enable_list_out;
    align_d       = (store_hit && param_addr_q == PARAM_ALIGN) ? param_value_q : align_q;
    status_d      = {5'h00, awake_in, suspend_in, sleep_in};
    if (reg_we) begin
      if (ptr_q >= OFS_KEY_FIRST && ptr_q <= OFS_KEY_LAST) begin
        key_d[key_idx[1:0]] = sh_q;
      end
      unique case (ptr_q)
        OFS_PROX3_HIGH:  prox3_high_d  = sh_q;
        OFS_AUX_LOW:     aux_low_d     = sh_q;
        OFS_AUX_HIGH:    aux_high_d    = sh_q;
        OFS_READBACK:    readback_d    = sh_q;
        OFS_PARAM_VALUE: param_value_d = sh_q;
        OFS_COMMAND: begin
          if (sh_q[7:5] == CMD_FETCH || sh_q[7:5] == CMD_STORE) begin
            param_req_d  = 1'b1;
            param_we_d   = (sh_q[7:5] == CMD_STORE);
            param_addr_d = sh_q[4:0];
          end
        end
        default: begin
          param_req_d = 1'b0;
        end
      endcase
    end
    if (param_ack) begin
      readback_d = param_rdata;
    end
    if (aux_valid_in) begin
      aux_low_d  = aux_data_in[7:0];
      aux_high_d = aux_data_in[15:8];
    end
    aligned_word = align_q[ALIGN_PROX1_BIT + int'(conv_chan_in)] ? conv_data_in[15:0] : conv_data_in[16:1];
    prox_word_d  = conv_valid_in ? aligned_word : prox_word_out;
    prox_chan_d  = conv_valid_in ? conv_chan_in : prox_word_chan_out;
    if (conv_valid_in && conv_chan_in == 2'h2) begin
      prox3_high_d = aligned_word[15:8];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prox3_high_q            <= RST_BYTE;
      aux_low_q               <= RST_BYTE;
      aux_high_q              <= RST_BYTE;
      readback_q              <= RST_BYTE;
      status_q                <= RST_BYTE;
      param_value_q           <= RST_BYTE;
      param_req_q             <= 1'b0;
      param_we_q              <= 1'b0;
      param_addr_q            <= 5'h00;
      channel_enable_list_out <= RST_BYTE;
      align_q                 <= RST_BYTE;
      key_q                   <= '{default: RST_BYTE};
      prox_word_out           <= 16'h0000;
      prox_word_chan_out      <= 2'h0;
      prox_word_valid_out     <= 1'b0;
    end else begin
      prox3_high_q            <= prox3_high_d;
      aux_low_q               <= aux_low_d;
      aux_high_q              <= aux_high_d;
      readback_q              <= readback_d;
      status_q                <= status_d;
      param_value_q           <= param_value_d;
      param_req_q             <= param_req_d;
      param_we_q              <= param_we_d;
      param_addr_q            <= param_addr_d;
      channel_enable_list_out <= channel_enable_list_d;
      align_q                 <= align_d;
      key_q                   <= key_d;
      prox_word_out           <= prox_word_d;
      prox_word_chan_out      <= prox_chan_d;
      prox_word_valid_out     <= conv_valid_in;
    end
  end

  // Input selection shadows of the three proximity channels
  for (genvar g = 0; g < PROX_CHANNELS; g++) begin : g_sel
    logic [7:0] sel_d;
    always_comb begin
      sel_d = prox_input_select_out[g*8 +: 8];
      if (store_hit && param_addr_q == PARAM_PROX1_SEL + 5'(g)) begin
        sel_d = param_value_q;
      end
    end
    always_ff @(posedge clk_in) begin
      if (rst_in) begin
        prox_input_select_out[g*8 +: 8] <= RST_BYTE;
      end else begin
        prox_input_select_out[g*8 +: 8] <= sel_d;
      end
    end
  end

  snr_param_ram u_param_ram (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .req_in    (param_req_q),
    .we_in     (param_we_q),
    .addr_in   (param_addr_q),
    .wdata_in  (param_value_q),
    .rdata_out (param_rdata),
    .ack_out   (param_ack)
  );

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_fetch_issue;
    param_req_q && !param_we_q;
  endsequence
  sequence s_fetch_answer;
    param_ack ##1 (readback_q == $past(param_rdata));
  endsequence

  chk_fetch_mailbox: assert property (s_fetch_issue |-> ##1 s_fetch_answer)
    else $error("mailbox did not take fetched parameter");
  chk_status_awake: assert property (awake_in |=> status_q[STAT_AWAKE_BIT])
    else $error("awake bit missing");
  chk_status_suspend: assert property ($rose(suspend_in) |=> status_q[STAT_SUSP_BIT] && $past(status_q[STAT_SUSP_BIT]) == 1'b0)
    else $error("suspend bit did not follow");
  chk_status_sleep: assert property (status_q[7:3] == 5'h00 && (status_q[STAT_SLEEP_BIT] == $past(sleep_in)))
    else $error("sleep bit or reserved status bits wrong");
  chk_unmapped_zero: assert property (ptr_q < OFS_PROX3_HIGH |-> rd_byte == RST_BYTE)
    else $error("parameter space visible in register map");
  chk_store_select: assert property (store_hit && param_addr_q == PARAM_PROX1_SEL |=> prox_input_select_out[7:0] == $past(param_value_q))
    else $error("channel one selection not stored");
  chk_align_low: assert property (conv_valid_in && align_q[ALIGN_PROX1_BIT + int'(conv_chan_in)] |=> prox_word_out == $past(conv_data_in[15:0]) && prox_word_valid_out)
    else $error("set alignment did not report low bits");
  chk_align_high: assert property (conv_valid_in && conv_chan_in == 2'h2 && !align_q[6] |=> prox3_high_q == $past(conv_data_in[16:9]))
    else $error("clear alignment did not report upper bits");
  chk_aux_capture: assert property (aux_valid_in |=> {aux_high_q, aux_low_q} == $past(aux_data_in))
    else $error("auxiliary word not captured");
  chk_key_store: assert property (reg_we && ptr_q == OFS_KEY_FIRST |=>
                                  key_q[0] == $past(sh_q) ##1 key_q[0] == $past(key_q[0]))
    else $error("key byte not held");
endmodule
`default_nettype wire

// file: bench/snr_host_model.sv
// Host controller model: two-wire bus master with open-drain data
`timescale 1ns/1ps
`default_nettype none
module snr_host_model
  import snr_pkg::*;
#(
  parameter int HALF = 8
) (
  input  wire logic clk_in,
  input  wire logic sda_line_in,
  output var  logic scl_out,
  output var  logic sda_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // Start or repeated start: data falls while the clock is high
  task automatic start();
    scl_out <= 1'b0;
    hold(2);
    sda_out <= 1'b1;
    hold(HALF);
    scl_out <= 1'b1;
    hold(HALF);
    sda_out <= 1'b0;
    hold(HALF);
  endtask
  // Data changes only while the clock is low, sampled at the end of high
  task automatic bit_io(input logic b, output logic r);
    scl_out <= 1'b0;
    hold(2);
    sda_out <= b;
    hold(HALF);
    scl_out <= 1'b1;
    hold(HALF);
    r = sda_line_in;
  endtask
  task automatic stop();
    scl_out <= 1'b0;
    hold(2);
    sda_out <= 1'b0;
    hold(HALF);
    scl_out <= 1'b1;
    hold(HALF);
    sda_out <= 1'b1;
    hold(HALF);
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // Last byte of a read is answered with a release, others pulled low
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule
`default_nettype wire

// file: bench/tb_snr_regs.sv
// Self-checking bench for the sensor host register block
`timescale 1ns/1ps
`default_nettype none
module tb_snr_regs
  import snr_pkg::*;
();
  logic        clk_in     = 1'b0;
  logic        rst_in     = 1'b1;
  logic        awake      = 1'b0;
  logic        suspend    = 1'b0;
  logic        sleep      = 1'b0;
  logic        conv_valid = 1'b0;
  logic [1:0]  conv_chan  = 2'h0;
  logic [16:0] conv_data  = 17'h0;
  logic        aux_valid  = 1'b0;
  logic [15:0] aux_data   = 16'h0;
  logic        scl;
  logic        sda_m;
  logic        sda_o;
  logic        sda_oen;
  logic        sda_line;
  logic [15:0] prox_word;
  logic [1:0]  prox_chan;
  logic        prox_valid;
  logic [23:0] prox_sel;
  logic [7:0]  ch_list;
  logic [15:0] rnd        = 16'h0013;
  int          bad_count  = 0;
  int          checked    = 0;

  always #25 clk_in = ~clk_in;
  // Pull-up on the data line: low if either party pulls it
  assign sda_line = sda_m & (sda_oen | sda_o);

  snr_regs u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_o),
    .sda_oen_out(sda_oen), .awake_in(awake), .suspend_in(suspend), .sleep_in(sleep),
    .conv_valid_in(conv_valid), .conv_chan_in(conv_chan), .conv_data_in(conv_data),
    .aux_valid_in(aux_valid), .aux_data_in(aux_data), .prox_word_out(prox_word),
    .prox_word_chan_out(prox_chan), .prox_word_valid_out(prox_valid),
    .prox_input_select_out(prox_sel), .channel_enable_list_out(ch_list)
  );
  snr_host_model u_host (.clk_in(clk_in), .sda_line_in(sda_line), .scl_out(scl), .sda_out(sda_m));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] aligned(input logic [7:0] enc, input logic [1:0] ch, input logic [16:0] raw);
    return enc[ALIGN_PROX1_BIT + ch] ? raw[15:0] : raw[16:1];
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Write the low n bytes of d, highest first, pointer advancing per byte
  task automatic reg_write(input logic [7:0] ofs, input logic [31:0] d, input int n);
    logic a;
    logic b;
    u_host.start();
    u_host.put_byte({DEV_ADDR, 1'b0}, a);
    u_host.put_byte(ofs, b);
    for (int i = n - 1; i >= 0; i--) begin
      u_host.put_byte(d[8*i +: 8], b);
    end
    u_host.stop();
    check(a, 1'b1);
  endtask
  task automatic reg_read(input logic [7:0] ofs, input int n, output logic [31:0] d);
    logic a;
    logic b;
    logic [7:0] v;
    u_host.start();
    u_host.put_byte({DEV_ADDR, 1'b0}, a);
    u_host.put_byte(ofs, b);
    u_host.start();
    u_host.put_byte({DEV_ADDR, 1'b1}, b);
    check(a & b, 1'b1);
    d = '0;
    for (int i = 0; i < n; i++) begin
      u_host.get_byte(i == n - 1, v);
      d = {d[23:0], v};
    end
    u_host.stop();
  endtask
  task automatic param_store(input logic [4:0] p, input logic [7:0] v);
    reg_write(OFS_PARAM_VALUE, {24'h0, v}, 1);
    reg_write(OFS_COMMAND, {24'h0, CMD_STORE, p}, 1);
  endtask
  task automatic convert(input logic [1:0] ch, input logic [16:0] raw, input logic [7:0] enc);
    conv_chan  <= ch;
    conv_data  <= raw;
    conv_valid <= 1'b1;
    @(posedge clk_in);
    conv_valid <= 1'b0;
    #1;
    check({prox_valid, prox_chan, prox_word}, {1'b1, ch, aligned(enc, ch, raw)});
    @(posedge clk_in);
    #1;
    check(prox_valid, 1'b0);
  endtask

  initial begin
    logic [31:0] d;
    logic [23:0] sel;
    logic [7:0]  enc;
    logic [31:0] key;
    logic [16:0] raw;
    logic [15:0] w;
    logic        ack;
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    reg_read(OFS_STATUS, 1, d);
    check(d, 32'h0);
    reg_read(OFS_AUX_LOW, 2, d);
    check(d, 32'h0);
    // One power state at a time; a host write to status must not stick
    for (int i = 0; i < 3; i++) begin
      {awake, suspend, sleep} <= 3'h1 << i;
      reg_write(OFS_STATUS, 32'hFF, 1);
      reg_read(OFS_STATUS, 1, d);
      check(d, 32'h1 << i);
    end
    param_store(PARAM_CHANNEL_ENABLE_LIST, 8'h07);
    check(ch_list, 8'h07);
    for (int i = 0; i < PROX_CHANNELS; i++) begin
      rnd = lfsr(rnd);
      sel[8*i +: 8] = rnd[7:0];
      param_store(5'(PARAM_PROX1_SEL + i), rnd[7:0]);
    end
    check(prox_sel, sel);
    reg_write(OFS_COMMAND, {24'h0, CMD_FETCH, 5'(PARAM_PROX1_SEL + 1)}, 1);
    reg_read(OFS_READBACK, 1, d);
    check(d, sel[15:8]);
    // Alignment corners first, then random patterns; low bits kept zero
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      enc = (k == 0) ? 8'h70 : (k == 1) ? 8'h00 : {1'b0, rnd[2:0], 4'h0};
      param_store(PARAM_ALIGN, enc);
      for (int c = 0; c < PROX_CHANNELS; c++) begin
        rnd = lfsr(rnd);
        raw = (k == 0) ? 17'h1FFFF : {rnd[0], lfsr(rnd)};
        convert(2'(c), raw, enc);
      end
      w = aligned(enc, 2'h2, raw);
      reg_read(OFS_PROX3_HIGH, 1, d);
      check(d, w[15:8]);
      aux_data  <= rnd;
      aux_valid <= 1'b1;
      @(posedge clk_in);
      aux_valid <= 1'b0;
      reg_read(OFS_AUX_LOW, 2, d);
      check(d, {16'h0, rnd[7:0], rnd[15:8]});
    end
    reg_write(OFS_COMMAND, {24'h0, CMD_FETCH, PARAM_ALIGN}, 1);
    reg_read(OFS_READBACK, 1, d);
    check(d, enc);
    // An unknown command code leaves the mailbox alone
    reg_write(OFS_COMMAND, {24'h0, 3'h7, PARAM_CHANNEL_ENABLE_LIST}, 1);
    reg_read(OFS_READBACK, 1, d);
    check(d, enc);
    reg_read(8'h05, 1, d);
    check(d, 32'h0);
    rnd = lfsr(rnd);
    key = {rnd, lfsr(rnd)};
    reg_write(OFS_KEY_FIRST, key, 4);
    reg_read(OFS_KEY_FIRST, 4, d);
    check(d, key);
    // A foreign address is left unanswered
    u_host.start();
    u_host.put_byte({~DEV_ADDR, 1'b0}, ack);
    u_host.stop();
    check(ack, 1'b0);
    close_out();
  end

  // Whole sequence needs about 27500 cycles; allow over three times that
  initial begin
    repeat (90000) @(posedge clk_in);
    bad_count++;
    close_out();
  end
endmodule
`default_nettype wire
